// *** rtl/ecc_pkg.sv ***
// Constants and register map of the configuration store control block
package ecc_pkg;
	localparam logic [11:0] ADDR_UPDATE    = 12'h232;
	localparam logic [11:0] ADDR_SEG_FIRST = 12'hA00;
	localparam logic [11:0] ADDR_SEG_LAST  = 12'hA16;
	localparam logic [11:0] ADDR_XFER_STAT = 12'hB00;
	localparam logic [11:0] ADDR_DATA_ERR  = 12'hB01;
	localparam logic [11:0] ADDR_STORE_CTL = 12'hB02;
	localparam logic [11:0] ADDR_STORE_WR  = 12'hB03;

	localparam int BIT_UPDATE = 0;
	localparam int BIT_BUSY   = 0;
	localparam int BIT_ERR    = 0;
	localparam int BIT_WREN   = 0;
	localparam int BIT_RELOAD = 1;
	localparam int BIT_STWR   = 0;

	localparam logic [4:0] SEG_COUNT = 5'h17;
	localparam int         STORE_AW  = 13;

	// Segment entry: [7:4] page of buffer address, [3:0] sixteen-byte blocks minus one
	localparam logic [7:0] OP_APPLY = 8'hE0;
	localparam logic [7:0] OP_END   = 8'hF0;

	// Default moves pages 0 to 2 whole, then applies the settings
	localparam logic [7:0] SEG_RESET [0:22] = '{
		0: 8'h0F, 1: 8'h1F, 2: 8'h2F, 3: 8'hE0, default: 8'hF0
	};

	localparam logic       WREN_RESET    = 1'b0;
	localparam logic       PIN_SYNC_INIT = 1'b1;
	localparam logic [7:0] SUM_RESET     = 8'h00;
endpackage

// *** rtl/ecc_sum_if.sv ***
// Carrier between the store sequencer and its checksum accumulator
interface ecc_sum_if;
	logic       clr;
	logic       add;
	logic [7:0] data;
	logic [7:0] sum;
	modport ctl (output clr, output add, output data, input sum);
	modport acc (input clr, input add, input data, output sum);
endinterface

// *** rtl/ecc_sync.sv ***
// Two flip-flop synchroniser for one pin level
module ecc_sync #(
	parameter logic INIT = 1'b0
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic d,
	output logic      q
);
	logic meta_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= INIT;
			q      <= INIT;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// *** rtl/ecc_sum.sv ***
// Running byte checksum over one store transfer
module ecc_sum (
	input  wire logic clk,
	input  wire logic rst,
	ecc_sum_if.acc    s
);
	logic [7:0] sum_q;

	assign s.sum = sum_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sum_q <= ecc_pkg::SUM_RESET;
		end else if (s.clr) begin
			sum_q <= ecc_pkg::SUM_RESET;
		end else if (s.add) begin
			sum_q <= sum_q + s.data;
		end
	end
endmodule

// *** rtl/ecc_top.sv ***
// Configuration store control: update trigger, segment table, store sequencer
// Functional notes
// - A write of 1 to bit 0 of the update register copies all buffer registers to active ones.
// - The update trigger clears itself, software never writes 0 to it.
// - Twenty-three segment table registers give start address and length of each run.
// - The sequencer obeys an end-of-data opcode in the table, and an apply-settings opcode on loads only.
// - After reset the table moves buffer pages 0 to 2 whole and then applies the settings.
// - A read-only status bit is 1 while a store transfer is still running.
// - With the status-pin select set, the transfer indication also drives the status pin.
// - A read-only error bit is set when a transfer finds incorrect data.
// - With the store-select pin low, the soft reload bit resets the device and reloads.
// - The soft reload bit clears itself one clock after the write that set it.
// - Store writes are blocked while the write-enable bit is 0, its reset value.
// - The store-write trigger starts a save and returns to 0 when the save is done.
module ecc_top (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [11:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata_q,
	input  wire logic       status_sel,
	input  wire logic       store_sel_pin,
	output logic            status_pin_q,
	output logic            update_q,
	output logic            soft_reset_q,
	output logic      [11:0] buf_addr_q,
	output logic            buf_wr_q,
	output logic      [7:0] buf_wdata_q,
	input  wire logic [7:0] buf_rdata,
	output logic            store_req_q,
	output logic            store_wr_q,
	output logic      [12:0] store_addr_q,
	output logic      [7:0] store_wdata_q,
	input  wire logic [7:0] store_rdata,
	input  wire logic       store_ack
);
	typedef enum logic [2:0] {
		S_IDLE, S_FETCH, S_ADDR, S_ISSUE, S_WAIT, S_NEXT, S_SUM, S_SUMWAIT
	} ecc_state_t;

	ecc_state_t state_q, state_d;
	logic [7:0]  seg_q [0:22];
	logic [4:0]  seg_idx_q, seg_idx_d;
	logic [7:0]  cnt_q, cnt_d;
	logic [11:0] buf_addr_d;
	logic [12:0] store_addr_d;
	logic [7:0]  store_wdata_d, buf_wdata_d;
	logic        store_req_d, store_wr_d, buf_wr_d, apply_d, done_d;
	logic        dir_save_q, wren_q, reload_q, stwr_q, err_q, err_d;
	logic        pin_s;

	ecc_sum_if sum_if ();

	ecc_sum u_sum (
		.clk (clk),
		.rst (rst),
		.s   (sum_if)
	);

	// Store-select pin comes from the board
	ecc_sync #(.INIT(ecc_pkg::PIN_SYNC_INIT)) u_pin_sync (
		.clk (clk),
		.rst (rst),
		.d   (store_sel_pin),
		.q   (pin_s)
	);

	wire       busy      = (state_q != S_IDLE);
	wire       pin_cause = status_sel & busy;
	wire       in_seg    = (reg_addr >= ecc_pkg::ADDR_SEG_FIRST) &&
	                       (reg_addr <= ecc_pkg::ADDR_SEG_LAST);
	wire [4:0] seg_ridx  = reg_addr[4:0];
	wire       wr_upd    = reg_wr && (reg_addr == ecc_pkg::ADDR_UPDATE) &&
	                       reg_wdata[ecc_pkg::BIT_UPDATE];
	wire       wr_seg    = reg_wr && in_seg;
	wire       wr_ctl    = reg_wr && (reg_addr == ecc_pkg::ADDR_STORE_CTL);
	wire       wr_rld    = wr_ctl && reg_wdata[ecc_pkg::BIT_RELOAD];
	wire       wr_stw    = reg_wr && (reg_addr == ecc_pkg::ADDR_STORE_WR) &&
	                       reg_wdata[ecc_pkg::BIT_STWR];
	// Protected store ignores the trigger; a running transfer does too
	wire       stw_ok    = wr_stw && wren_q && !busy;
	wire       start_sv  = stwr_q && !busy;
	wire       start_ld  = reload_q && !pin_s && !busy && !stwr_q;
	wire [7:0] entry     = (seg_idx_q < ecc_pkg::SEG_COUNT) ? seg_q[seg_idx_q] : ecc_pkg::OP_END;
	wire       seg_end   = (entry == ecc_pkg::OP_END);
	wire       seg_apply = (entry == ecc_pkg::OP_APPLY);
	wire [7:0] rd_mux    =
		in_seg ? seg_q[seg_ridx] :
		(reg_addr == ecc_pkg::ADDR_XFER_STAT) ? {7'h00, busy} :
		(reg_addr == ecc_pkg::ADDR_DATA_ERR)  ? {7'h00, err_q} :
		(reg_addr == ecc_pkg::ADDR_STORE_CTL) ? {6'h00, reload_q, wren_q} :
		(reg_addr == ecc_pkg::ADDR_STORE_WR)  ? {7'h00, stwr_q} :
		8'h00;

	assign sum_if.clr  = start_sv || start_ld;
	assign sum_if.add  = (state_q == S_WAIT) && store_ack;
	assign sum_if.data = dir_save_q ? store_wdata_q : store_rdata;

	always_comb begin
		state_d       = state_q;
		seg_idx_d     = seg_idx_q;
		cnt_d         = cnt_q;
		buf_addr_d    = buf_addr_q;
		store_addr_d  = store_addr_q;
		store_req_d   = store_req_q;
		store_wr_d    = store_wr_q;
		store_wdata_d = store_wdata_q;
		buf_wr_d      = 1'b0;
		buf_wdata_d   = buf_wdata_q;
		apply_d       = 1'b0;
		done_d        = 1'b0;
		err_d         = err_q;
		case (state_q)
			S_IDLE: begin
				if (start_sv || start_ld) begin
					state_d      = S_FETCH;
					seg_idx_d    = 5'h00;
					store_addr_d = 13'h0000;
					err_d        = 1'b0;
				end
			end
			S_FETCH: begin
				if (seg_end) begin
					state_d = S_SUM;
				end else if (seg_apply) begin
					apply_d   = !dir_save_q;
					seg_idx_d = seg_idx_q + 5'h01;
				end else begin
					buf_addr_d = {entry[7:4], 8'h00};
					cnt_d      = {entry[3:0], 4'hF};
					state_d    = S_ADDR;
				end
			end
			// Buffer read data is valid one cycle after the address
			S_ADDR: begin
				state_d = S_ISSUE;
			end
			S_ISSUE: begin
				store_req_d = 1'b1;
				store_wr_d  = dir_save_q;
				if (dir_save_q) begin
					store_wdata_d = buf_rdata;
				end
				state_d = S_WAIT;
			end
			S_WAIT: begin
				if (store_ack) begin
					store_req_d  = 1'b0;
					store_addr_d = store_addr_q + 13'h0001;
					buf_wr_d     = !dir_save_q;
					buf_wdata_d  = store_rdata;
					state_d      = S_NEXT;
				end
			end
			// Address held here so the buffer write lands where it was read for
			S_NEXT: begin
				if (cnt_q == 8'h00) begin
					seg_idx_d = seg_idx_q + 5'h01;
					state_d   = S_FETCH;
				end else begin
					cnt_d      = cnt_q - 8'h01;
					buf_addr_d = buf_addr_q + 12'h001;
					state_d    = S_ADDR;
				end
			end
			S_SUM: begin
				store_req_d   = 1'b1;
				store_wr_d    = dir_save_q;
				store_wdata_d = sum_if.sum;
				state_d       = S_SUMWAIT;
			end
			S_SUMWAIT: begin
				if (store_ack) begin
					store_req_d = 1'b0;
					if (!dir_save_q) begin
						err_d = (store_rdata != sum_if.sum);
					end
					done_d  = 1'b1;
					state_d = S_IDLE;
				end
			end
			default: begin
				state_d = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q       <= S_IDLE;
			seg_idx_q     <= 5'h00;
			cnt_q         <= 8'h00;
			buf_addr_q    <= 12'h000;
			buf_wr_q      <= 1'b0;
			buf_wdata_q   <= 8'h00;
			store_addr_q  <= 13'h0000;
			store_req_q   <= 1'b0;
			store_wr_q    <= 1'b0;
			store_wdata_q <= 8'h00;
			err_q         <= 1'b0;
		end else begin
			state_q       <= state_d;
			seg_idx_q     <= seg_idx_d;
			cnt_q         <= cnt_d;
			buf_addr_q    <= buf_addr_d;
			buf_wr_q      <= buf_wr_d;
			buf_wdata_q   <= buf_wdata_d;
			store_addr_q  <= store_addr_d;
			store_req_q   <= store_req_d;
			store_wr_q    <= store_wr_d;
			store_wdata_q <= store_wdata_d;
			err_q         <= err_d;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seg_q <= ecc_pkg::SEG_RESET;
		end else if (wr_seg) begin
			seg_q[seg_ridx] <= reg_wdata;
		end
	end

	// Register-port side effects
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			update_q     <= 1'b0;
			reload_q     <= 1'b0;
			soft_reset_q <= 1'b0;
			wren_q       <= ecc_pkg::WREN_RESET;
		end else begin
			update_q     <= wr_upd || apply_d;
			reload_q     <= wr_rld;
			soft_reset_q <= start_ld;
			if (wr_ctl) begin
				wren_q <= reg_wdata[ecc_pkg::BIT_WREN];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stwr_q     <= 1'b0;
			dir_save_q <= 1'b0;
		end else begin
			if (stw_ok) begin
				stwr_q <= 1'b1;
			end else if (done_d && dir_save_q) begin
				stwr_q <= 1'b0;
			end
			if (start_sv || start_ld) begin
				dir_save_q <= start_sv;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata_q  <= 8'h00;
			status_pin_q <= 1'b0;
		end else begin
			status_pin_q <= pin_cause;
			if (reg_rd) begin
				reg_rdata_q <= rd_mux;
			end
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	property p_update;
		wr_upd |=> update_q;
	endproperty
	a_update: assert property (p_update) else $error("update pulse missing");
	property p_upd_reads_zero;
		reg_rd && (reg_addr == ecc_pkg::ADDR_UPDATE) |=> (reg_rdata_q == 8'h00);
	endproperty
	a_upd_reads_zero: assert property (p_upd_reads_zero) else $error("update bit stuck");
	property p_seg_write;
		wr_seg |=> (seg_q[$past(seg_ridx)] == $past(reg_wdata));
	endproperty
	a_seg_write: assert property (p_seg_write) else $error("segment write lost");
	property p_end_op;
		(state_q == S_FETCH) && seg_end |=> (state_q == S_SUM) ##1 store_req_q;
	endproperty
	a_end_op: assert property (p_end_op) else $error("end opcode not obeyed");
	property p_apply_op;
		(state_q == S_FETCH) && seg_apply && !dir_save_q |=> update_q;
	endproperty
	a_apply_op: assert property (p_apply_op) else $error("apply opcode not obeyed");
	property p_busy_read;
		reg_rd && (reg_addr == ecc_pkg::ADDR_XFER_STAT) |=> (reg_rdata_q[0] == $past(busy));
	endproperty
	a_busy_read: assert property (p_busy_read) else $error("status bit wrong");
	property p_status_pin;
		##1 (status_pin_q == $past(pin_cause));
	endproperty
	a_status_pin: assert property (p_status_pin) else $error("status pin wrong");
	// A reload may legally start right after the flag is set and clear it
	property p_err;
		(state_q == S_SUMWAIT) && store_ack && !dir_save_q && (store_rdata != sum_if.sum)
			|=> err_q && (state_q == S_IDLE) ##1 (err_q || (state_q == S_FETCH));
	endproperty
	a_err: assert property (p_err) else $error("data error not flagged");
	property p_reload;
		start_ld |=> soft_reset_q && (state_q == S_FETCH) && !dir_save_q;
	endproperty
	a_reload: assert property (p_reload) else $error("soft reload not started");
	property p_reload_clear;
		!wr_rld |=> !reload_q;
	endproperty
	a_reload_clear: assert property (p_reload_clear) else $error("reload bit stuck");
	property p_protect;
		wr_stw && !wren_q && !stwr_q |=> !stwr_q;
	endproperty
	a_protect: assert property (p_protect) else $error("protected store write taken");
	property p_save_done;
		(state_q == S_SUMWAIT) && store_ack && dir_save_q |=> !stwr_q && !busy;
	endproperty
	a_save_done: assert property (p_save_done) else $error("store trigger not cleared");
endmodule

// *** verification/ecc_store_model.sv ***
// Behavioural nonvolatile store and buffer register bank
module ecc_store_model (
	input  wire logic        clk,
	input  wire logic        store_req_q,
	input  wire logic        store_wr_q,
	input  wire logic [12:0] store_addr_q,
	input  wire logic [7:0]  store_wdata_q,
	output logic      [7:0]  store_rdata,
	output logic             store_ack,
	input  wire logic [11:0] buf_addr_q,
	input  wire logic        buf_wr_q,
	input  wire logic [7:0]  buf_wdata_q,
	output logic      [7:0]  buf_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem  [0:8191];
	logic [7:0] bufm [0:4095];
	integer     seed = 18205;
	int         wait_n = 0;
	int         wr_n = 0;
	initial begin
		store_ack = 1'b0;
		store_rdata = 8'h00;
		buf_rdata = 8'h00;
	end
	// Slow answers on purpose; data scrambled outside the ack cycle
	always @(posedge clk) begin
		store_ack <= 1'b0;
		store_rdata <= ~store_rdata;
		if (store_req_q && !store_ack) begin
			if (wait_n == 0) begin
				store_ack <= 1'b1;
				wait_n <= $unsigned($random(seed)) % 4;
				if (store_wr_q) begin
					mem[store_addr_q] <= store_wdata_q;
					wr_n <= wr_n + 1;
				end else begin
					store_rdata <= mem[store_addr_q];
				end
			end else begin
				wait_n <= wait_n - 1;
			end
		end
	end
	always @(posedge clk) begin
		buf_rdata <= bufm[buf_addr_q];
		if (buf_wr_q) begin
			bufm[buf_addr_q] <= buf_wdata_q;
		end
	end
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the configuration store control block
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] A_ST = ecc_pkg::ADDR_XFER_STAT;
	localparam logic [11:0] A_CT = ecc_pkg::ADDR_STORE_CTL;
	localparam logic [11:0] A_WR = ecc_pkg::ADDR_STORE_WR;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0]  reg_wdata = 8'h00;
	logic        status_sel = 1'b0;
	logic        store_sel_pin = 1'b1;
	logic [7:0]  reg_rdata_q, buf_wdata_q, buf_rdata, store_wdata_q, store_rdata;
	logic        status_pin_q, update_q, soft_reset_q, buf_wr_q, store_req_q;
	logic        store_wr_q, store_ack;
	logic [11:0] buf_addr_q;
	logic [12:0] store_addr_q;
	integer      seed = 18205;
	int          err_count = 0;
	int          checks = 0;
	int          upd_n = 0;
	int          srst_n = 0;
	int          n0, s0, bad;
	logic [7:0]  rv, sum;
	logic [7:0]  img [0:767];

	ecc_top dut_u (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q,
		.status_sel, .store_sel_pin, .status_pin_q, .update_q, .soft_reset_q, .buf_addr_q,
		.buf_wr_q, .buf_wdata_q, .buf_rdata, .store_req_q, .store_wr_q, .store_addr_q,
		.store_wdata_q, .store_rdata, .store_ack);
	ecc_store_model mdl_u (.clk, .store_req_q, .store_wr_q, .store_addr_q, .store_wdata_q,
		.store_rdata, .store_ack, .buf_addr_q, .buf_wr_q, .buf_wdata_q, .buf_rdata);

	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		upd_n <= upd_n + int'(update_q === 1'b1);
		srst_n <= srst_n + int'(soft_reset_q === 1'b1);
	end

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata_q;
	endtask
	task automatic wait_idle();
		rv = 8'h01;
		for (int n = 0; n < 8000 && rv !== 8'h00; n++) begin
			rd(A_ST, rv);
		end
		chk("busy_end", rv, 8'h00);
	endtask
	task automatic reload(input logic [7:0] d);
		n0 = upd_n;
		s0 = srst_n;
		wr(A_CT, d);
		wait_idle();
	endtask
	function automatic logic [7:0] exp_seg(input int i);
		return (i < 3) ? {i[3:0], 4'hF} : ((i == 3) ? 8'hE0 : 8'hF0);
	endfunction
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		print_verdict();
	end

	initial begin
		for (int i = 0; i < 8192; i++) mdl_u.mem[i] = 8'h00;
		for (int i = 0; i < 4096; i++) mdl_u.bufm[i] = 8'($random(seed));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 23; i++) begin
			rd(12'(ecc_pkg::ADDR_SEG_FIRST + i), rv);
			chk("seg_reset", rv, exp_seg(i));
		end
		for (int i = 4; i < 23; i++) begin
			sum = 8'($random(seed));
			wr(12'(ecc_pkg::ADDR_SEG_FIRST + i), sum);
			rd(12'(ecc_pkg::ADDR_SEG_FIRST + i), rv);
			chk("seg_rw", rv, sum);
			wr(12'(ecc_pkg::ADDR_SEG_FIRST + i), 8'hF0);
		end
		rd(12'h100, rv);
		chk("unmapped", rv, 8'h00);
		rd(A_CT, rv);
		chk("wren_reset", rv, 8'h00);
		wr(A_WR, 8'h01);
		rd(A_WR, rv);
		chk("save_blocked", rv, 8'h00);
		repeat (8) @(posedge clk);
		chk("no_store_wr", 16'(mdl_u.wr_n), 16'h0000);
		n0 = upd_n;
		wr(ecc_pkg::ADDR_UPDATE, 8'h01);
		repeat (3) @(posedge clk);
		chk("update_pulses", 16'(upd_n - n0), 16'h0001);
		rd(ecc_pkg::ADDR_UPDATE, rv);
		chk("update_clear", rv, 8'h00);
		wr(A_CT, 8'h01);
		status_sel <= 1'b1;
		wr(A_WR, 8'h01);
		rd(A_ST, rv);
		chk("save_busy", rv, 8'h01);
		chk("pin_busy", status_pin_q, 1'b1);
		rd(A_WR, rv);
		chk("save_pending", rv, 8'h01);
		wait_idle();
		rd(A_WR, rv);
		chk("save_clear", rv, 8'h00);
		chk("pin_idle", status_pin_q, 1'b0);
		bad = 0;
		sum = 8'h00;
		for (int i = 0; i < 768; i++) begin
			bad += int'(mdl_u.mem[i] !== mdl_u.bufm[i]);
			sum += mdl_u.bufm[i];
			img[i] = mdl_u.bufm[i];
			mdl_u.bufm[i] = 8'h00;
		end
		chk("save_image", 16'(bad), 16'h0000);
		chk("save_sum", mdl_u.mem[768], sum);
		status_sel <= 1'b0;
		store_sel_pin <= 1'b0;
		repeat (4) @(posedge clk);
		reload(8'h03);
		chk("soft_reset", 16'(srst_n - s0), 16'h0001);
		chk("apply_op", 16'(upd_n - n0), 16'h0001);
		chk("pin_unsel", status_pin_q, 1'b0);
		bad = 0;
		for (int i = 0; i < 768; i++) bad += int'(mdl_u.bufm[i] !== img[i]);
		chk("load_image", 16'(bad), 16'h0000);
		rd(A_CT, rv);
		chk("reload_clear", rv[1], 1'b0);
		rd(ecc_pkg::ADDR_DATA_ERR, rv);
		chk("err_clean", rv, 8'h00);
		mdl_u.mem[768] = ~mdl_u.mem[768];
		reload(8'h02);
		rd(ecc_pkg::ADDR_DATA_ERR, rv);
		chk("err_set", rv, 8'h01);
		store_sel_pin <= 1'b1;
		repeat (4) @(posedge clk);
		reload(8'h02);
		chk("reload_pin_high", 16'(srst_n - s0), 16'h0000);
		print_verdict();
	end
endmodule
